// File: include/gistm_pkg.sv
// Package for the global interrupt summary and countdown timer block
package gistm_pkg;
    // Register byte addresses
    localparam logic [7:0] GISTM_SUMMARY_OFS = 8'h18;
    localparam logic [7:0] GISTM_TIMER_OFS = 8'h1c;
    localparam logic [7:0] GISTM_EVT_STATUS_OFS = 8'h30;
    localparam logic [7:0] GISTM_EVT_MASK_OFS = 8'h34;
    // Summary register field positions
    localparam int GISTM_DIR_BIT = 16;
    localparam int GISTM_OE_A_BIT = 17;
    localparam int GISTM_OE_B_BIT = 18;
    localparam int GISTM_GATE_LSB = 8;
    localparam int GISTM_SRC_LSB = 0;
    // Timer register field positions
    localparam int GISTM_RUN_BIT = 31;
    localparam int GISTM_CONT_BIT = 30;
    localparam int GISTM_BRS_BIT = 29;
    localparam int GISTM_PRELOAD_W = 24;
    // Reset values
    localparam logic [31:0] GISTM_SUMMARY_RST = 32'h0001_0000;
    localparam logic [31:0] GISTM_TIMER_RST = 32'h0000_0000;
    // Timing: one unit is 1/(2*link_base_clock), in picoseconds
    localparam int GISTM_UNIT_PS = 80140;
    localparam int GISTM_CLK_PS = 4000;
    localparam int GISTM_UNIT_CYC = (GISTM_UNIT_PS / GISTM_CLK_PS < 1) ? 1 :
        GISTM_UNIT_PS / GISTM_CLK_PS;
    // Event bits of the block's own status register
    localparam int GISTM_EVT_EXPIRE = 0;
    localparam int GISTM_EVT_BRS = 1;
endpackage

// File: src/gistm_top.sv
// Global interrupt summary, AV port direction and countdown timer
// How it works
// - Bit 16 set: port A transmits, pins input; port B takes opposite role.
// - Bit 11 gates async module interrupt to external line.
// - Bit 10 gates iso transmit module interrupt to external line.
// - Bit 9 gates iso receive module interrupt to external line.
// - Bit 8 gates link layer module interrupt to external line.
// - Read-only bits 3..0 show which module sources are active.
// - Timer run bit 31: write 1 starts, write 0 stops.
// - Continuous bit 30 reloads on expiry; clear means interrupt once, stop.
// - Bus reset start bit 29 starts timing at each bus reset.
// - Preload is 24 bits in bits 23..0.
// - Timer counts in units of about 80.14 ns.
// - Start copies preload to hidden counter, decremented each unit.
// - Reaching zero pulses the timer flag toward the link ack register.
// - With bus reset start set, the run bit is ignored.
// - Continuous mode restarts even if flag unacknowledged.
// - Source bits clear themselves when module interrupts clear.
// - Active-low interrupt stays asserted while any enabled source remains.
// - Bits 17, 18 enable port A, B outputs; zero releases the port.
`timescale 1ns/100ps
`default_nettype none
module gistm_top
    import gistm_pkg::*;
#(
    parameter int UNIT_CYC = gistm_pkg::GISTM_UNIT_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Module interrupt sources, same clock
    input wire logic link_layer_irq_source,
    input wire logic iso_rx_irq_source,
    input wire logic iso_tx_irq_source,
    input wire logic async_module_irq_source,
    // Bus reset start, asynchronous level from the link
    input wire logic bus_reset_in,
    // Timer expiry flag toward the link ack register
    output logic countdown_expire,
    // External interrupt, active low
    output logic int_n,
    // AV port control
    output logic port_a_direction,
    output logic av_port_a_oe,
    output logic av_port_b_oe,
    output logic av_port_b_input,
    // Block's own event interrupt
    output logic evt_irq
);
    import gistm_pkg::*;

    // The prescaler is 16 bits wide, so longer units cannot be counted
    if (UNIT_CYC < 1 || UNIT_CYC > 65536) begin : g_unit_check
        $error("UNIT_CYC must lie between 1 and 65536");
    end

    // Bus address phase capture
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic [31:0] summary_ctl;
    logic [31:0] timer_ctl;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic [23:0] count;
    logic running;
    logic [15:0] unit_cnt;
    logic unit_tick;
    logic brs_s1;
    logic brs_s2;
    logic brs_q;
    logic brs_rise;
    logic [3:0] src;
    logic [3:0] gate;
    logic expire;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            rd_pend <= hsel && htrans[1] && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic wr_sum;
    logic wr_tim;
    logic wr_stat;
    logic wr_mask;
    assign wr_sum = wr_pend && hit(addr_q, GISTM_SUMMARY_OFS);
    assign wr_tim = wr_pend && hit(addr_q, GISTM_TIMER_OFS);
    assign wr_stat = wr_pend && hit(addr_q, GISTM_EVT_STATUS_OFS);
    assign wr_mask = wr_pend && hit(addr_q, GISTM_EVT_MASK_OFS);

    // Only gate and port bits are stored; source bits are live
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            summary_ctl <= GISTM_SUMMARY_RST;
        end else if (wr_sum) begin
            summary_ctl <= {13'h0000, hwdata[18:16], 4'h0, hwdata[11:8], 8'h00};
        end
    end

    assign src = {async_module_irq_source, iso_tx_irq_source, iso_rx_irq_source,
        link_layer_irq_source};
    assign gate = summary_ctl[GISTM_GATE_LSB +: 4];

    // Any gated source holds the line low
    assign int_n = ~|(src & gate);

    assign port_a_direction = summary_ctl[GISTM_DIR_BIT];
    assign av_port_b_input = ~summary_ctl[GISTM_DIR_BIT];
    assign av_port_a_oe = summary_ctl[GISTM_OE_A_BIT];
    assign av_port_b_oe = summary_ctl[GISTM_OE_B_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_ctl <= GISTM_TIMER_RST;
        end else if (wr_tim) begin
            timer_ctl <= {hwdata[31:29], 5'h00, hwdata[23:0]};
        end
    end

    // Bus reset level passes two flops before the edge detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brs_s1 <= 1'b0;
            brs_s2 <= 1'b0;
            brs_q <= 1'b0;
        end else begin
            brs_s1 <= bus_reset_in;
            brs_s2 <= brs_s1;
            brs_q <= brs_s2;
        end
    end
    assign brs_rise = brs_s2 && !brs_q;

    // Time unit prescaler, restarted on each start so the first unit is full
    logic start;
    logic brs_mode;
    assign brs_mode = timer_ctl[GISTM_BRS_BIT];
    assign start = brs_mode ? brs_rise :
        (wr_tim && hwdata[GISTM_RUN_BIT] && !hwdata[GISTM_BRS_BIT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_cnt <= 16'h0000;
        end else if (start || !running || unit_tick) begin
            unit_cnt <= 16'h0000;
        end else begin
            unit_cnt <= unit_cnt + 16'h0001;
        end
    end
    assign unit_tick = running && (unit_cnt == 16'(UNIT_CYC - 1));

    assign expire = unit_tick && (count == 24'h000001 || count == 24'h000000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running <= 1'b0;
            count <= 24'h000000;
        end else if (start) begin
            running <= 1'b1;
            count <= timer_ctl[GISTM_PRELOAD_W-1:0];
            if (wr_tim) begin
                count <= hwdata[GISTM_PRELOAD_W-1:0];
            end
        end else if (wr_tim && !brs_mode && !hwdata[GISTM_RUN_BIT]) begin
            running <= 1'b0;
        end else if (expire) begin
            // Reload does not wait for acknowledgement of the flag
            running <= timer_ctl[GISTM_CONT_BIT];
            count <= timer_ctl[GISTM_PRELOAD_W-1:0];
        end else if (unit_tick) begin
            count <= count - 24'h000001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            countdown_expire <= 1'b0;
        end else begin
            countdown_expire <= expire;
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_status <= 2'b00;
        end else begin
            evt_status <= (evt_status & ~(wr_stat ? hwdata[1:0] : 2'b00))
                | {brs_rise, expire};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_mask <= 2'b00;
        end else if (wr_mask) begin
            evt_mask <= hwdata[1:0];
        end
    end
    assign evt_irq = |(evt_status & evt_mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (hit(haddr[7:0], GISTM_SUMMARY_OFS)) begin
                hrdata <= {summary_ctl[31:4], src};
            end else if (hit(haddr[7:0], GISTM_TIMER_OFS)) begin
                hrdata <= timer_ctl;
            end else if (hit(haddr[7:0], GISTM_EVT_STATUS_OFS)) begin
                hrdata <= {30'h0000_0000, evt_status};
            end else if (hit(haddr[7:0], GISTM_EVT_MASK_OFS)) begin
                hrdata <= {30'h0000_0000, evt_mask};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // Interrupt gating
    gate_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src[0] && gate[0]) |-> !int_n) else $error("int_n not low");

    gate_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ((src & gate) == 4'h0) |-> int_n) else $error("int_n low w/o source");

    gate_async_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src[3] && gate[3]) |-> !int_n) else $error("async interrupt not passed");

    gate_itx_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src[2] && gate[2]) |-> !int_n) else $error("iso tx interrupt not passed");

    gate_irx_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src[1] && gate[1]) |-> !int_n) else $error("iso rx interrupt not passed");

    gate_none_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (gate == 4'h0) |-> int_n) else $error("interrupt with all gates closed");

    src_gone_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src == 4'h0) |-> int_n) else $error("interrupt after sources cleared");

    // Sources are shown live on a summary read
    src_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans[1] && !hwrite && hit(haddr[7:0], GISTM_SUMMARY_OFS))
        |=> hrdata[3:0] == $past(src)) else $error("source bits not read back");

    // Port control
    port_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
        port_a_direction != av_port_b_input) else $error("ports same role");

    dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sum |=> port_a_direction == $past(hwdata[GISTM_DIR_BIT]))
        else $error("direction not written");

    oe_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sum |=> av_port_a_oe == $past(hwdata[GISTM_OE_A_BIT])) else $error("oe a");

    oe_b_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_sum |=> av_port_b_oe == $past(hwdata[GISTM_OE_B_BIT])) else $error("oe b");

    // Timer
    preload_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_tim |=> timer_ctl[23:0] == $past(hwdata[23:0])) else $error("preload lost");

    brs_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (brs_mode && brs_rise) |-> start) else $error("bus reset did not start timer");

    run_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
        brs_mode |-> (start == brs_rise)) else $error("run bit acted in bus reset mode");

    idle_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!running && !start) |=> count == $past(count)) else $error("count moved idle");

    unit_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (unit_tick && UNIT_CYC > 1) |=> !unit_tick) else $error("unit too short");

    expire_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        expire |=> evt_status[GISTM_EVT_EXPIRE]) else $error("expiry event lost");

    start_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start |=> running) else $error("timer not running after start");

    stop_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_tim && !start && !brs_mode && !hwdata[GISTM_RUN_BIT]) |=> !running)
        else $error("timer not stopped");

    oneshot_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (expire && !start && !wr_tim && !timer_ctl[GISTM_CONT_BIT]) |=> !running)
        else $error("one-shot kept running");

    cont_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (expire && !start && !wr_tim && timer_ctl[GISTM_CONT_BIT]) |=>
        (running && count == $past(timer_ctl[23:0]))) else $error("no reload");

    expire_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        expire |=> countdown_expire) else $error("expiry flag missing");

    // A start or a stop write in the same cycle takes precedence over the step
    unit_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (unit_tick && !expire && !start && !wr_tim) |=> count == $past(count) - 24'h000001)
        else $error("count step wrong");
endmodule
`default_nettype wire

// File: verification/gistm_test.sv
// Self-checking bench for the interrupt summary and countdown timer block
`timescale 1ns/100ps
`default_nettype none
module gistm_test;
    import gistm_pkg::*;
    logic hclk, hresetn, hwrite, bus_reset_in, hreadyout, hresp, hready;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [3:0] src;
    logic countdown_expire, int_n, port_a_direction, av_port_a_oe, av_port_b_oe;
    logic av_port_b_input, evt_irq;
    logic [11:0] rows [6];
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    assign hready = hreadyout;
    gistm_top #(.UNIT_CYC(2)) u_gistm_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_layer_irq_source(src[0]),
        .iso_rx_irq_source(src[1]), .iso_tx_irq_source(src[2]),
        .async_module_irq_source(src[3]), .bus_reset_in(bus_reset_in),
        .countdown_expire(countdown_expire), .int_n(int_n),
        .port_a_direction(port_a_direction), .av_port_a_oe(av_port_a_oe),
        .av_port_b_oe(av_port_b_oe), .av_port_b_input(av_port_b_input), .evt_irq(evt_irq));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single word transfer; the wait is bounded only by the global timeout
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Cycles until the next expiry pulse, capped at lim
    task automatic gap(input string what, input int lim, input int lo, input int hi);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (countdown_expire !== 1'b1 && n < lim);
        check(what, {31'h0, n >= lo && n <= hi}, 32'h1);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        hclk = 0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        hresetn = 0;
        hwrite = 0;
        bus_reset_in = 0;
        haddr = 0;
        hwdata = 0;
        htrans = 0;
        src = 0;
        // Rows: {oe_b, oe_a, dir, gates, sources, expected int_n}
        rows = '{12'b000_0000_1111_1, 12'b001_1000_1111_0, 12'b010_0100_0100_0,
            12'b100_0010_1101_1, 12'b111_0001_0001_0, 12'b011_1111_0000_1};
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        bus(0, GISTM_SUMMARY_OFS, 0);
        check("summary reset", rd, 32'h0001_0000);
        check("dir reset", {31'h0, port_a_direction}, 32'h1);
        bus(0, GISTM_TIMER_OFS, 0);
        check("timer reset", rd, 32'h0);
        bus(0, 8'h40, 0);
        check("unmapped read", rd, 32'h0);
        bus(1, GISTM_TIMER_OFS, 32'h00ab_cdef);
        bus(0, GISTM_TIMER_OFS, 0);
        check("preload", rd, 32'h00ab_cdef);
        $display("reset and map test done");
        foreach (rows[i]) begin
            src <= rows[i][4:1];
            bus(1, GISTM_SUMMARY_OFS, {13'h0, rows[i][11:9], 4'h0, rows[i][8:5], 8'h0});
            @(negedge hclk);
            check("int_n", {31'h0, int_n}, {31'h0, rows[i][0]});
            check("dir", {31'h0, port_a_direction}, {31'h0, rows[i][9]});
            check("port b role", {31'h0, av_port_b_input}, {31'h0, ~rows[i][9]});
            check("oe a", {31'h0, av_port_a_oe}, {31'h0, rows[i][10]});
            check("oe b", {31'h0, av_port_b_oe}, {31'h0, rows[i][11]});
            bus(0, GISTM_SUMMARY_OFS, 0);
            check("summary", rd, {13'h0, rows[i][11:9], 4'h0, rows[i][8:5], 4'h0,
                rows[i][4:1]});
        end
        $display("summary table test done");
        bus(1, GISTM_TIMER_OFS, 32'h8000_0005);
        gap("one shot expiry", 40, 8, 14);
        gap("one shot stops", 30, 30, 30);
        bus(1, GISTM_TIMER_OFS, 32'hc000_0003);
        gap("continuous first", 40, 5, 10);
        gap("continuous again", 40, 5, 8);
        gap("continuous third", 40, 5, 8);
        bus(1, GISTM_TIMER_OFS, 32'h4000_0003);
        gap("stopped", 30, 30, 30);
        $display("timer test done");
        bus(1, GISTM_TIMER_OFS, 32'ha000_0003);
        gap("run ignored", 30, 30, 30);
        @(posedge hclk);
        bus_reset_in <= 1;
        gap("bus reset start", 40, 5, 14);
        @(posedge hclk);
        bus_reset_in <= 0;
        bus(0, GISTM_EVT_STATUS_OFS, 0);
        check("event status", rd, 32'h3);
        check("event irq masked", {31'h0, evt_irq}, 32'h0);
        bus(1, GISTM_EVT_MASK_OFS, 32'h3);
        @(negedge hclk);
        check("event irq", {31'h0, evt_irq}, 32'h1);
        bus(1, GISTM_EVT_STATUS_OFS, 32'h3);
        bus(0, GISTM_EVT_STATUS_OFS, 0);
        check("event cleared", rd, 32'h0);
        check("event irq low", {31'h0, evt_irq}, 32'h0);
        $display("bus reset and event test done");
        test_done();
    end
endmodule
`default_nettype wire
